//--- inc/wdt_cfg.svh
/*
  Constants for the watchdog timeout counter: register offsets, field
  positions, reset values and timing counts.
  Assumes it is included by its bare name from the package and the design.
*/
// Summary of operation
// - 12-bit prescaler feeding free-running 6-bit counter.
// - overflow resets after 2^13-16 or 2^18-16 cycles.
// - service write clears counter and prescaler stages 5-12.
// - overflow drives reset low 32 cycles, sets cause.
// - stop instruction clears the prescaler.
// - service read returns reset vector low byte.
// - power-on clears prescaler after 4096 cycles.
// - internal reset clears prescaler and counter.
// - reset vector fetch clears the prescaler.
// - disable and rate inputs follow configuration bits.
// - monitor mode overvoltage on either pin disables.
// - break with reset-pin overvoltage disables watchdog.
// - never raises interrupt or DMA requests.
// - keeps counting in wait mode.
// - stop mode gates counting off until exit.
// - clocked by oscillator clock, not bus clock.
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ----------------------------------------------------------------
// register map (byte addresses, one word each)
// ----------------------------------------------------------------
`define WDT_OFS_SERVICE   16'hFFFF
`define WDT_OFS_CONTROL   16'h0000
`define WDT_OFS_STATUS    16'h0004
`define WDT_OFS_VECTOR    16'h0008

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WDT_CTL_DISABLE   0
`define WDT_CTL_RATE      1
`define WDT_STS_CAUSE     0
`define WDT_STS_STOPPED   1
`define WDT_STS_RSTOUT    2
`define WDT_STS_POR_DONE  3
`define WDT_CNT_LSB       8
`define WDT_PRE_KEEP      4

// ----------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------
`define WDT_CTL_RESET     2'h0
`define WDT_VEC_RESET     8'h00
`define WDT_RST_CYCLES    6'h20
`define WDT_POR_CYCLES    13'h1000
`define WDT_SHORT_TAP     6
`define WDT_LONG_TAP      11

`endif

//--- inc/wdt_pkg.sv
/*
  Types for the watchdog timeout counter.
  Assumes wdt_cfg.svh is on the include path.
*/
`include "wdt_cfg.svh"

package wdt_pkg;

  // avalon request bundle
  typedef struct packed {
    logic        read;
    logic        write;
    logic [15:0] address;
    logic [31:0] writedata;
  } wdt_req_t;

  // chip-level events reaching the watchdog
  typedef struct packed {
    logic stop_exec;     // stop instruction executed
    logic stop_mode;     // in stop mode, clock gated
    logic int_reset;     // internal reset pulse
    logic vector_fetch;  // reset vector fetch
    logic monitor_mode;
    logic break_state;
    logic hv_irq_pin;    // overvoltage on ext_interrupt_pin_one
    logic hv_rst_pin;    // overvoltage on reset pin
  } wdt_evt_t;

  // output sequencer states
  typedef enum logic [1:0] {
    WDT_ST_RUN  = 2'b01,
    WDT_ST_PULL = 2'b10
  } wdt_state_t;

endpackage

//--- hw/wdt_core.sv
/*
  Watchdog timeout counter: prescaler, 6-bit counter, reset pulse output
  and an Avalon-MM slave with waitrequest for its registers.
  Assumes clk is the oscillator clock; event inputs come from logic on
  clk except the overvoltage detects, which are synchronised here.
*/
// Our own choice: the Avalon-MM slave port.
`include "wdt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module wdt_core #(
  parameter int PRE_W = 12,
  parameter int CNT_W = 6
) (
  input  wire logic             clk,            // oscillator clock
  input  wire logic             arst_n,         // async reset, active low
  input  wire wdt_pkg::wdt_req_t req,           // avalon request
  input  wire logic [7:0]       reset_vec_lo,   // reset vector low byte
  input  wire wdt_pkg::wdt_evt_t evt,           // chip events
  output logic [31:0]           readdata,       // avalon read data
  output logic                  waitrequest,    // avalon stall
  output logic                  ext_reset_n,    // reset pin drive, low active
  output logic                  ext_reset_oe,   // reset pin output enable
  output logic                  watchdog_cause_flag // cause flag
);

  // ----------------------------------------------------------------
  // synchronisers for pin overvoltage detects
  // ----------------------------------------------------------------
  // the overvoltage detects are analogue levels, asynchronous to clk
  logic [1:0] hv_s1_reg, hv_s2_reg;
  // first stage is read only by the second
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      hv_s1_reg <= 2'h0;
      hv_s2_reg <= 2'h0;
    end
    else
    begin
      hv_s1_reg <= {evt.hv_irq_pin, evt.hv_rst_pin};
      hv_s2_reg <= hv_s1_reg;
    end

  // ----------------------------------------------------------------
  // register file and bus slave
  // ----------------------------------------------------------------
  logic [1:0]  ctl_reg, ctl_next;
  logic        wait_reg, wait_next;
  logic        done;
  logic [31:0] rd_reg, rd_next;
  logic        svc_wr;
  logic        cause_reg, cause_next;
  logic        por_done_reg;
  wdt_pkg::wdt_state_t st_reg;
  logic [PRE_W-1:0] pre_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic        hit;

  // hit opens an access; done is the edge where waitrequest is seen low,
  // the only edge at which a write is allowed to land
  assign hit    = (req.read | req.write) & wait_reg;
  assign done   = (req.read | req.write) & ~wait_reg;
  assign svc_wr = done & req.write & (req.address == `WDT_OFS_SERVICE);

  // one wait state: ack registered, unmapped reads give zero
  always_comb
  begin
    ctl_next = ctl_reg;
    rd_next  = 32'h0;
    wait_next = ~hit;
    if (done && req.write && req.address == `WDT_OFS_CONTROL)
      ctl_next = req.writedata[1:0];
    if (hit && req.read)
      unique case (req.address)
        `WDT_OFS_SERVICE: rd_next = {24'h0, reset_vec_lo};
        `WDT_OFS_CONTROL: rd_next = {30'h0, ctl_reg};
        `WDT_OFS_STATUS:  rd_next = {16'h0, 2'h0, cnt_reg, 4'h0, por_done_reg,
                                     ~ext_reset_n, evt.stop_mode, cause_reg};
        `WDT_OFS_VECTOR:  rd_next = {24'h0, reset_vec_lo};
        default:          rd_next = 32'h0;
      endcase
  end

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      ctl_reg <= `WDT_CTL_RESET;
      wait_reg <= 1'b1;
      rd_reg  <= 32'h0;
    end
    else
    begin
      ctl_reg <= ctl_next;
      wait_reg <= wait_next;
      rd_reg  <= rd_next;
    end

  assign readdata    = rd_reg;
  assign waitrequest = wait_reg;

  // ----------------------------------------------------------------
  // disable decode
  // ----------------------------------------------------------------
  logic wd_off, rate_short;
  // monitor mode honours either pin, break only the reset pin
  assign wd_off = ctl_reg[`WDT_CTL_DISABLE]
                | (evt.monitor_mode & (hv_s2_reg[1] | hv_s2_reg[0]))
                | (evt.break_state & hv_s2_reg[0]);
  assign rate_short = ctl_reg[`WDT_CTL_RATE];

  // ----------------------------------------------------------------
  // power-on prescaler clear after 4096 cycles
  // ----------------------------------------------------------------
  logic [12:0] por_reg, por_next;
  logic        por_clr;
  assign por_clr = (por_reg == `WDT_POR_CYCLES - 13'h1) & ~por_done_reg;
  logic        por_done_next;
  // the count freezes once done, so the clear can never repeat
  always_comb
  begin
    por_next      = por_done_reg ? por_reg : por_reg + 13'h1;
    por_done_next = por_done_reg | por_clr;
  end
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      por_reg      <= 13'h0;
      por_done_reg <= 1'b0;
    end
    else
    begin
      por_reg      <= por_next;
      por_done_reg <= por_done_next;
    end

  // ----------------------------------------------------------------
  // prescaler and counter
  // ----------------------------------------------------------------
  // a full timeout = 64 counter steps of the tap period, giving 2^n - 2^4
  // service keeps the low stages, so a timeout loses at most 15 cycles
  logic [PRE_W-1:0] pre_next;
  logic [CNT_W-1:0] cnt_next;
  logic             tick, ovf, pre_clr_all;
  logic [PRE_W-1:0] tap_mask;
  assign tap_mask = rate_short ? PRE_W'((1 << (`WDT_SHORT_TAP + 1)) - 1)
                               : PRE_W'((1 << (`WDT_LONG_TAP + 1)) - 1);
  assign tick = ((pre_reg & tap_mask) == tap_mask);
  assign ovf  = tick & (&cnt_reg) & (st_reg == wdt_pkg::WDT_ST_RUN);
  // prescaler-only clears from stop, power-on and vector fetch
  assign pre_clr_all = evt.stop_exec | por_clr | evt.vector_fetch;

  always_comb
  begin
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    if (wd_off || evt.int_reset)
    begin
      pre_next = '0;
      cnt_next = '0;
    end
    else if (evt.stop_mode)
      pre_next = '0;
    else
    begin
      // wait mode is not an input: counting goes on regardless
      pre_next = pre_reg + PRE_W'(1);
      if (tick)
        cnt_next = cnt_reg + CNT_W'(1);
      if (pre_clr_all)
        pre_next = '0;
      if (svc_wr)
      begin
        cnt_next = '0;
        pre_next = pre_next & PRE_W'((1 << `WDT_PRE_KEEP) - 1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      pre_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
    end

  // ----------------------------------------------------------------
  // reset pulse sequencer and cause flag
  // ----------------------------------------------------------------
  wdt_pkg::wdt_state_t st_next;
  logic [5:0] pulse_reg, pulse_next;
  logic       rst_n_reg, rst_n_next;
  // separate enable flop keeps the pin output glitch free
  logic       oe_reg, oe_next;
  // the cause flag is sticky; no software clear exists here
  always_comb
  begin
    st_next    = st_reg;
    pulse_next = pulse_reg;
    rst_n_next = rst_n_reg;
    oe_next    = oe_reg;
    cause_next = cause_reg;
    unique case (st_reg)
      wdt_pkg::WDT_ST_RUN:
        if (ovf && !wd_off)
        begin
          st_next    = wdt_pkg::WDT_ST_PULL;
          pulse_next = `WDT_RST_CYCLES - 6'h1;
          rst_n_next = 1'b0;
          oe_next    = 1'b1;
          cause_next = 1'b1;
        end
      wdt_pkg::WDT_ST_PULL:
        if (pulse_reg == 6'h0)
        begin
          st_next    = wdt_pkg::WDT_ST_RUN;
          rst_n_next = 1'b1;
          oe_next    = 1'b0;
        end
        else
          pulse_next = pulse_reg - 6'h1;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      st_reg    <= wdt_pkg::WDT_ST_RUN;
      pulse_reg <= 6'h0;
      rst_n_reg <= 1'b1;
      oe_reg    <= 1'b0;
      cause_reg <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      pulse_reg <= pulse_next;
      rst_n_reg <= rst_n_next;
      oe_reg    <= oe_next;
      cause_reg <= cause_next;
    end

  // no interrupt or dma request port exists at all
  assign ext_reset_n         = rst_n_reg;
  assign ext_reset_oe        = oe_reg; // pin driven only while pulled low
  assign watchdog_cause_flag = cause_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_pulse_len: assert property ($fell(ext_reset_n) |-> !ext_reset_n [*8])
    else $error("reset pulse too short");
  a_pulse_cause: assert property ($fell(ext_reset_n) |-> watchdog_cause_flag)
    else $error("cause flag not set with reset");
  a_svc_clear: assert property (svc_wr && !wd_off && !evt.int_reset && !evt.stop_mode
                                |=> cnt_reg == '0)
    else $error("service did not clear counter");
  a_off_held: assert property (wd_off |=> pre_reg == '0 && cnt_reg == '0)
    else $error("disabled watchdog counting");
  a_off_noreset: assert property (wd_off && st_reg == wdt_pkg::WDT_ST_RUN |=> ext_reset_n)
    else $error("reset while disabled");
  a_int_clear: assert property (evt.int_reset |=> cnt_reg == '0)
    else $error("internal reset left counter");
  a_stop_hold: assert property (evt.stop_mode && !wd_off && !evt.int_reset
                                |=> $stable(cnt_reg) && pre_reg == '0)
    else $error("counter moved in stop mode");
  a_stop_pre: assert property (evt.stop_exec && !svc_wr |=> pre_reg == '0)
    else $error("stop left prescaler");
  a_fetch_pre: assert property (evt.vector_fetch && !svc_wr |=> pre_reg == '0)
    else $error("vector fetch left prescaler");
  a_svc_read: assert property (hit && req.read && req.address == `WDT_OFS_SERVICE
                               |=> readdata == {24'h0, $past(reset_vec_lo)})
    else $error("service read wrong data");
  a_ack_one: assert property (!waitrequest |=> waitrequest)
    else $error("ack held two cycles");
  a_pulse_exact: assert property ($rose(ext_reset_n) |-> !$past(ext_reset_n, 32) && $past(ext_reset_n, 33))
    else $error("reset pulse not 32 cycles");
  a_cause_sticky: assert property (watchdog_cause_flag |=> watchdog_cause_flag)
    else $error("cause flag dropped");
  a_ctl_write: assert property (!waitrequest && req.write && req.address == `WDT_OFS_CONTROL
                                |=> ctl_reg == $past(req.writedata[1:0]))
    else $error("control write lost");
  a_por_once: assert property (por_clr |=> por_done_reg && pre_reg == '0)
    else $error("power-on clear missing");

  c_timeout:  cover property ($fell(ext_reset_n));
  c_service:  cover property (svc_wr && cnt_reg != '0);
  c_pulse_end: cover property ($rose(ext_reset_n));
  c_monitor:  cover property (evt.monitor_mode && wd_off);
  c_por:      cover property (por_clr);

endmodule // wdt_core

`default_nettype wire

//--- test/wdt_chip_model.sv
/*
  Chip reset logic facing the watchdog: resolves the pulled-up reset pin,
  measures each low pulse and answers with one internal reset pulse.
  Assumes the watchdog drives the pin from clk.
*/
`timescale 1ns/1ps
`default_nettype none

module wdt_chip_model (
  input  wire logic       clk,       // oscillator clock
  input  wire logic       arst_n,    // async reset, low active
  input  wire logic       pin_drv_n, // watchdog pin drive
  input  wire logic       pin_oe,    // watchdog pin enable
  output logic            pin,       // resolved pin level
  output logic            int_rst,   // internal reset pulse
  output logic [7:0]      pulses,    // finished low pulses
  output logic [7:0]      last_len   // cycles of last pulse
);
  logic [7:0] low_cnt;

  // pull-up: an undriven pin reads high, so a lost enable shows as no reset
  assign pin = pin_oe ? pin_drv_n : 1'b1;

  // count low cycles; a released pin turns into one internal reset cycle
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      low_cnt  <= 8'h00;
      pulses   <= 8'h00;
      last_len <= 8'h00;
      int_rst  <= 1'b0;
    end
    else
    begin
      int_rst <= 1'b0;
      if (!pin)
        low_cnt <= low_cnt + 8'h01;
      else if (low_cnt != 8'h00)
      begin
        last_len <= low_cnt;
        pulses   <= pulses + 8'h01;
        low_cnt  <= 8'h00;
        int_rst  <= 1'b1;
      end
    end
  end
endmodule // wdt_chip_model

`default_nettype wire

//--- test/wdt_core_test.sv
/*
  Self-checking bench for the watchdog: register reads, disable, both
  rates, overflow pulse, servicing, internal reset, stop and overvoltage.
  Assumes wdt_cfg.svh on the include path and one wait state per access.
*/
`include "wdt_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module wdt_core_test;
  logic              clk = 1'b0;
  logic              arst_n = 1'b0;
  wdt_pkg::wdt_req_t req = '0;
  wdt_pkg::wdt_evt_t evt = '0;
  wdt_pkg::wdt_evt_t evt_in;
  logic [7:0]        vec = 8'h00;
  logic [31:0]       readdata;
  logic [31:0]       q;
  logic              waitrequest, drv_n, oe, cause, pin, int_rst;
  logic [7:0]        pulses, last_len;
  int                n_mismatch = 0;
  int                checks = 0;
  int                n;

  wdt_core dut (.clk(clk), .arst_n(arst_n), .req(req), .reset_vec_lo(vec), .evt(evt_in),
    .readdata(readdata), .waitrequest(waitrequest), .ext_reset_n(drv_n), .ext_reset_oe(oe),
    .watchdog_cause_flag(cause));
  wdt_chip_model chip (.clk(clk), .arst_n(arst_n), .pin_drv_n(drv_n), .pin_oe(oe), .pin(pin),
    .int_rst(int_rst), .pulses(pulses), .last_len(last_len));

  always #5 clk = ~clk;

  // the chip's internal reset joins the bench's own pulses
  always_comb
  begin
    evt_in = evt;
    evt_in.int_reset = evt.int_reset | int_rst;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // shortest timeout after a service: 2^13 - 2^4 oscillator cycles
  function automatic int tmo_short();
    return (2 ** 13) - (2 ** 4);
  endfunction

  // range compare; an unknown never counts as inside
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // one access held until waitrequest is seen low; only the hang guard ends a stall
  task automatic bus(input logic rd, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{read: rd, write: ~rd, address: a, writedata: d};
    do
    begin
      @(posedge clk);
    end
    while (waitrequest !== 1'b0);
    q = readdata;
    req <= '0;
  endtask

  // run some cycles and expect the reset pin never to fall
  task automatic quiet(input int c);
    logic [31:0] p0;
    p0 = {24'h0, pulses};
    repeat (c) @(posedge clk);
    chk({24'h0, pulses}, p0, p0);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard, sized above the roughly 82k cycles of the tests
  initial
  begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h1292));
    vec <= 8'($urandom);
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    bus(1, `WDT_OFS_CONTROL, 0);
    chk(q, 0, 0);
    bus(1, `WDT_OFS_SERVICE, 0);
    chk(q, {24'h0, vec}, {24'h0, vec});
    bus(1, 16'h0010, 0);
    chk(q, 0, 0);
    bus(1, `WDT_OFS_STATUS, 0);
    chk((q >> `WDT_STS_POR_DONE) & 32'h1, 0, 0);
    $display("test regs done");
    bus(0, `WDT_OFS_CONTROL, 32'h3);
    quiet(tmo_short() + 300);
    bus(1, `WDT_OFS_STATUS, 0);
    chk((q >> `WDT_CNT_LSB) & 32'h3F, 0, 0);
    chk((q >> `WDT_STS_POR_DONE) & 32'h1, 1, 1);
    $display("test disable done");
    bus(0, `WDT_OFS_CONTROL, 32'h0);
    bus(0, `WDT_OFS_SERVICE, $urandom);
    quiet(tmo_short() + 300);
    $display("test long rate done");
    bus(0, `WDT_OFS_CONTROL, 32'h2);
    bus(0, `WDT_OFS_SERVICE, $urandom);
    n = 0;
    while (pin !== 1'b0 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    chk(n, tmo_short() - 64, tmo_short() + 136);
    chk(cause, 1, 1);
    repeat (40) @(posedge clk);
    chk(last_len, 32, 32);
    bus(1, `WDT_OFS_STATUS, 0);
    chk(q & 32'h1, 1, 1);
    $display("test overflow done");
    // servicing at random spacing, with prescaler clears mixed in
    repeat (3)
    begin
      bus(0, `WDT_OFS_SERVICE, $urandom);
      evt.stop_exec <= 1'b1;
      evt.vector_fetch <= 1'b1;
      @(posedge clk);
      evt.stop_exec <= 1'b0;
      evt.vector_fetch <= 1'b0;
      quiet(4000 + $urandom_range(0, 3000));
    end
    $display("test service done");
    bus(0, `WDT_OFS_SERVICE, $urandom);
    repeat (2000) @(posedge clk);
    bus(1, `WDT_OFS_STATUS, 0);
    chk((q >> `WDT_CNT_LSB) & 32'h3F, 14, 16);
    evt.int_reset <= 1'b1;
    @(posedge clk);
    evt.int_reset <= 1'b0;
    bus(1, `WDT_OFS_STATUS, 0);
    chk((q >> `WDT_CNT_LSB) & 32'h3F, 0, 0);
    $display("test internal reset done");
    bus(0, `WDT_OFS_SERVICE, $urandom);
    evt.stop_mode <= 1'b1;
    bus(1, `WDT_OFS_STATUS, 0);
    chk((q >> `WDT_STS_STOPPED) & 32'h1, 1, 1);
    quiet(tmo_short() + 300);
    evt.stop_mode <= 1'b0;
    $display("test stop done");
    // monitor with either pin high, then break with the reset pin high
    for (int i = 0; i < 3; i++)
    begin
      bus(0, `WDT_OFS_SERVICE, $urandom);
      evt.monitor_mode <= (i < 2);
      evt.break_state <= (i == 2);
      evt.hv_irq_pin <= (i == 0);
      evt.hv_rst_pin <= (i != 0);
      quiet(tmo_short() + 300);
    end
    $display("test overvoltage done");
    tally_and_finish();
  end
endmodule // wdt_core_test

`default_nettype wire
